//--- mlf_prog_port.sv
// Summary of operation
// R1: Six protection bits; only erase restores ones (here reset also restores them).
// R2: Lock mode 2 blocks programming, freezes fuses.
// R3: Lock mode 3 blocks programming and read-back.
// R4: App write lock suppresses self-writes to app.
// R5: App read lock stops boot reading app.
// R6: Boot write lock suppresses self-writes to boot.
// R7: Boot read lock stops app reading boot.
// R8: Boot read lock masks interrupts in boot.
// R9: Boot size field, default 11.
// R10: Reset vector fuse picks boot or zero.
// R11: Brown-out enable fuse active at 0.
// R12: Serial download fuse, default 0, parallel only.
// R13: Clock select field, default 0010.
// R14: Chip erase leaves fuses untouched.
// R15: Three identification bytes at 000 to 002.
// R16: Calibration byte at high byte of 000.
// R17: Programmer pulses last at least 500ns.
// R18: Strobe rising edge performs selected action.
// R19: Write or output-enable runs loaded command.
// R20: Byte selects choose low, high, second high.
// R21: Ready/busy low while programming.
// R22: Data driven only while output-enable low.
// R23: Action codes: address, data, command, idle.
// R24: Command byte encodings as defined.
// R25: Undefined command bytes do nothing.
`timescale 1ns/1ps
`include "mlf_defs.svh"

module mlf_prog_port (
  input  wire logic              CLOCK,             // 40 MHz system clock
  input  wire logic              RST_N,             // Synchronous reset, active low
  input  wire logic              ACTION_SELECT_0,   // Action code bit 0 pin
  input  wire logic              ACTION_SELECT_1,   // Action code bit 1 pin
  input  wire logic              BYTE_SELECT_A,     // Low or high byte select pin
  input  wire logic              BYTE_SELECT_B,     // Second high byte select pin
  input  wire logic              OUT_ENABLE_N,      // Output enable pin, active low
  input  wire logic              WRITE_N,           // Write pulse pin, active low
  input  wire logic              PAGE_LATCH_STROBE, // Page buffer latch pin
  input  wire logic              CRYSTAL_IN_STROBE, // Action strobe pin
  input  wire logic [7:0]        DATA_IN,           // Data bus input side
  output logic      [7:0]        DATA_OUT,          // Data bus output side
  output logic                   DATA_OE,           // Data bus drive enable
  output logic                   READY_BUSY_OUT,    // 1 ready, 0 busy
  output mlf_pkg::mlf_mem_op_t   MEM_OP,            // Memory operation code
  output logic                   MEM_STROBE,        // One-cycle memory request
  output logic      [15:0]       MEM_ADDR,          // Memory address
  output logic      [7:0]        MEM_WDATA,         // Memory write byte
  input  wire logic [7:0]        MEM_RDATA,         // Memory read byte, one cycle late
  input  wire logic              SPM_REQ,           // Self-program store request
  input  wire logic              SPM_TO_BOOT,       // Store targets boot section
  input  wire logic              LPM_REQ,           // Program memory load request
  input  wire logic              LPM_TO_BOOT,       // Load targets boot section
  input  wire logic              RUN_IN_BOOT,       // Code executes from boot section
  output logic                   SPM_GRANT,         // Store permitted
  output logic                   LPM_GRANT,         // Load permitted
  output logic                   IRQ_BLOCK,         // Interrupts forced off
  output logic      [5:0]        LOCK_BITS,         // Protection bits
  output logic      [1:0]        BOOT_SIZE_SEL,     // Boot size field
  output logic                   RESET_VECTOR_TO_BOOT, // Reset vector fuse
  output logic      [15:0]       RESET_VECTOR,      // Selected reset address
  output logic                   BROWNOUT_ENABLE,   // Brown-out detector on
  output logic                   BROWNOUT_LEVEL_FUSE, // Brown-out level fuse
  output logic                   SERIAL_DOWNLOAD_ENABLE, // Serial download allowed
  output logic      [3:0]        CLOCK_SOURCE_SEL   // Clock source field
);
  import mlf_pkg::*;

  localparam logic [11:0] BUSY_CYCLES = 12'(`MLF_PROG_CYCLES);
  // Strobes rest low and active-low pins high; the synchroniser resets to these levels so
  // that no strobe edge is seen in the first cycles after reset.
  localparam logic [15:0] PINS_IDLE = `MLF_PIN_IDLE;

  mlf_state_t s_reg;
  mlf_state_t s_next;

  logic [15:0] pins;
  logic        xtal_rise;
  logic        wr_fall;
  logic        oe_fall;
  logic        page_latch_strobe_rise;
  logic [7:0]  din;
  logic        lock_a_prog;
  logic        lock_ab_prog;
  logic [15:0] boot_start;
  logic [7:0]  rd_byte;

  assign pins = {DATA_IN, CRYSTAL_IN_STROBE, PAGE_LATCH_STROBE, WRITE_N, OUT_ENABLE_N,
                 BYTE_SELECT_B, BYTE_SELECT_A, ACTION_SELECT_1, ACTION_SELECT_0};

  // Every pin edge acts three clocks after it reaches the pin: two synchroniser stages and
  // one compare against the previous sample. Select and data pins share those stages, so
  // they only need to settle before the strobe edge that uses them. A pulse of the
  // minimum width spans twenty clocks, which leaves ample margin for the lag.
  always_comb begin
    s_next = s_reg;
    din = s_reg.s2[15:`MLF_PIN_DATA_LSB];
    xtal_rise = s_reg.s2[`MLF_PIN_XTAL] & ~s_reg.prev[3]; // R18
    page_latch_strobe_rise = s_reg.s2[`MLF_PIN_PAGE_LATCH_STROBE] & ~s_reg.prev[2];
    wr_fall = ~s_reg.s2[`MLF_PIN_WR_N] & s_reg.prev[1]; // R19
    oe_fall = ~s_reg.s2[`MLF_PIN_OE_N] & s_reg.prev[0]; // R19
    lock_a_prog = ~s_reg.locks[`MLF_LK_MEM_A]; // R2
    lock_ab_prog = lock_a_prog & ~s_reg.locks[`MLF_LK_MEM_B]; // R3
    // The pins come from an external programmer, so nothing reads them before two stages.
    s_next.s1 = pins;
    s_next.s2 = s_reg.s1;
    s_next.prev = {s_reg.s2[`MLF_PIN_XTAL], s_reg.s2[`MLF_PIN_PAGE_LATCH_STROBE],
                   s_reg.s2[`MLF_PIN_WR_N], s_reg.s2[`MLF_PIN_OE_N]};
    s_next.mem_strobe = 1'b0;

    unique case (s_reg.fuse_hi[`MLF_FH_SIZE_MSB:`MLF_FH_SIZE_LSB]) // R9
      2'b00: boot_start = `MLF_BOOT_START_0;
      2'b01: boot_start = `MLF_BOOT_START_1;
      2'b10: boot_start = `MLF_BOOT_START_2;
      2'b11: boot_start = `MLF_BOOT_START_3;
    endcase
    s_next.reset_vec = s_reg.fuse_hi[`MLF_FH_RST_BOOT] ? `MLF_APP_RESET_VEC : boot_start; // R10

    // Self-programming access filters.
    s_next.spm_grant = SPM_REQ & (SPM_TO_BOOT ? s_reg.locks[`MLF_LK_BOOT_WR]  // R6
                                              : s_reg.locks[`MLF_LK_APP_WR]); // R4
    s_next.lpm_grant = LPM_REQ;
    if (RUN_IN_BOOT && !LPM_TO_BOOT && !s_reg.locks[`MLF_LK_APP_RD]) begin
      s_next.lpm_grant = 1'b0; // R5
    end
    if (!RUN_IN_BOOT && LPM_TO_BOOT && !s_reg.locks[`MLF_LK_BOOT_RD]) begin
      s_next.lpm_grant = 1'b0; // R7
    end
    s_next.irq_block = RUN_IN_BOOT & ~s_reg.locks[`MLF_LK_BOOT_RD]; // R8

    // Self-timed programming; the programmer polls ready before the next command.
    if (s_reg.busy_cnt != 12'h000) begin
      s_next.busy_cnt = s_reg.busy_cnt - 12'h001;
    end
    s_next.ready = (s_next.busy_cnt == 12'h000); // R21

    if (xtal_rise && s_reg.ready) begin
      unique case (mlf_action_t'(s_reg.s2[`MLF_PIN_XA1:`MLF_PIN_XA0])) // R23
        MLF_ACT_ADDR: begin
          if (s_reg.s2[`MLF_PIN_BS1]) begin // R20
            s_next.addr_hi = din;
          end else begin
            s_next.addr_lo = din;
          end
        end
        MLF_ACT_DATA: begin
          if (s_reg.s2[`MLF_PIN_BS1]) begin // R20
            s_next.data_hi = din;
          end else begin
            s_next.data_lo = din;
          end
        end
        MLF_ACT_CMD: s_next.cmd = din;
        MLF_ACT_IDLE: ;
      endcase
    end

    if (page_latch_strobe_rise && s_reg.ready && s_reg.cmd == MLF_CMD_WR_FLASH) begin
      s_next.mem_op = s_reg.s2[`MLF_PIN_BS1] ? MLF_MOP_LATCH_HI : MLF_MOP_LATCH_LO;
      s_next.mem_wdata = s_reg.s2[`MLF_PIN_BS1] ? s_reg.data_hi : s_reg.data_lo;
      s_next.mem_addr = {s_reg.addr_hi, s_reg.addr_lo};
      s_next.mem_strobe = 1'b1;
    end

    if (wr_fall && s_reg.ready) begin
      s_next.mem_addr = {s_reg.addr_hi, s_reg.addr_lo};
      s_next.mem_wdata = s_reg.data_lo;
      case (s_reg.cmd) // R24
        MLF_CMD_ERASE: begin
          s_next.locks = `MLF_LOCK_RESET; // R1
          s_next.mem_op = MLF_MOP_ERASE; // R14
          s_next.mem_strobe = 1'b1;
          s_next.busy_cnt = BUSY_CYCLES;
          s_next.ready = 1'b0;
        end
        MLF_CMD_WR_FUSE: begin
          if (!lock_a_prog) begin // R2
            if (s_reg.s2[`MLF_PIN_BS1]) begin
              s_next.fuse_hi = s_reg.data_lo[2:0];
            end else begin
              s_next.fuse_lo = s_reg.data_lo | (8'h01 << `MLF_FL_RSVD);
            end
          end
          // A refused write still runs the busy time, so the programmer sees the same handshake.
          s_next.busy_cnt = BUSY_CYCLES;
          s_next.ready = 1'b0;
        end
        MLF_CMD_WR_LOCK: begin
          // The AND can only program bits; a programmed bit returns to one through erase or reset alone.
          s_next.locks = s_reg.locks & s_reg.data_lo[5:0]; // R1
          s_next.busy_cnt = BUSY_CYCLES;
          s_next.ready = 1'b0;
        end
        MLF_CMD_WR_FLASH, MLF_CMD_WR_EE: begin
          if (!lock_a_prog) begin // R2
            s_next.mem_op = (s_reg.cmd == MLF_CMD_WR_EE) ? MLF_MOP_EE_WR : MLF_MOP_PAGE_WR;
            s_next.mem_strobe = 1'b1;
          end
          s_next.busy_cnt = BUSY_CYCLES;
          s_next.ready = 1'b0;
        end
        default: ; // R25
      endcase
    end

    // A read is requested on the falling edge of output enable, or on any address
    // change seen while it is held low, so that the bus stays current.
    if (!s_reg.s2[`MLF_PIN_OE_N] && s_reg.ready &&
        (s_reg.cmd == MLF_CMD_RD_FLASH || s_reg.cmd == MLF_CMD_RD_EE) &&
        (oe_fall || s_reg.mem_addr != {s_reg.addr_hi, s_reg.addr_lo})) begin
      s_next.mem_op = (s_reg.cmd == MLF_CMD_RD_EE) ? MLF_MOP_RD_EE : MLF_MOP_RD_FLASH; // R19
      s_next.mem_addr = {s_reg.addr_hi, s_reg.addr_lo};
      s_next.mem_strobe = 1'b1;
    end

    unique case (s_reg.cmd)
      MLF_CMD_RD_SIG: begin
        if (s_reg.s2[`MLF_PIN_BS1] && s_reg.addr_lo == 8'h00) begin
          rd_byte = `MLF_CAL_BYTE; // R16
        end else begin
          unique case (s_reg.addr_lo) // R15
            8'h00: rd_byte = `MLF_SIG_BYTE_0;
            8'h01: rd_byte = `MLF_SIG_BYTE_1;
            8'h02: rd_byte = `MLF_SIG_BYTE_2;
            default: rd_byte = 8'h00;
          endcase
        end
      end
      MLF_CMD_RD_FUSE: begin
        if (s_reg.s2[`MLF_PIN_BS2]) begin // R20
          rd_byte = {5'h1f, s_reg.fuse_hi};
        end else if (s_reg.s2[`MLF_PIN_BS1]) begin
          rd_byte = {2'h3, s_reg.locks};
        end else begin
          rd_byte = s_reg.fuse_lo;
        end
      end
      MLF_CMD_RD_FLASH, MLF_CMD_RD_EE: begin
        // Memory returns the byte at the latched address; the byte select is not passed to it.
        rd_byte = lock_ab_prog ? `MLF_BLOCKED_READ : MEM_RDATA; // R3
      end
      default: rd_byte = 8'h00;
    endcase

    // Drive lags the pin by the synchroniser; the programmer must not drive in that gap.
    s_next.data_oe = ~s_reg.s2[`MLF_PIN_OE_N]; // R22
    s_next.data_out = rd_byte;

    if (!RST_N) begin
      s_next = '0;
      s_next.s1 = PINS_IDLE;
      s_next.s2 = PINS_IDLE;
      s_next.prev = {PINS_IDLE[`MLF_PIN_XTAL], PINS_IDLE[`MLF_PIN_PAGE_LATCH_STROBE],
                     PINS_IDLE[`MLF_PIN_WR_N], PINS_IDLE[`MLF_PIN_OE_N]};
      s_next.locks = `MLF_LOCK_RESET; // R1
      s_next.fuse_lo = `MLF_FUSE_LO_RESET; // R11
      s_next.fuse_hi = `MLF_FUSE_HI_RESET; // R9
      s_next.ready = 1'b1;
      s_next.reset_vec = `MLF_APP_RESET_VEC;
      s_next.cmd = MLF_CMD_NOP;
      s_next.mem_op = MLF_MOP_NONE;
      // The bus, the memory strobe and the grants are named here as well, so that the
      // reset state of what the core and memory act on does not rest on the clear above.
      s_next.data_oe = 1'b0;
      s_next.data_out = 8'h00;
      s_next.mem_strobe = 1'b0;
      s_next.spm_grant = 1'b0;
      s_next.lpm_grant = 1'b0;
      s_next.irq_block = 1'b0;
      s_next.busy_cnt = 12'h000;
    end

    // The enables are the fuses inverted. They get flops of their own, loaded on the same
    // edge as the fuse, so that no inverter stands between a flop and its port.
    s_next.bod_on = ~s_next.fuse_lo[`MLF_FL_BOD_EN]; // R11
    s_next.ser_on = ~s_next.fuse_lo[`MLF_FL_SER_EN]; // R12
  end

  always_ff @(posedge CLOCK) begin
    s_reg <= s_next;
  end

  assign DATA_OUT = s_reg.data_out;
  assign DATA_OE = s_reg.data_oe;
  assign READY_BUSY_OUT = s_reg.ready;
  assign MEM_OP = s_reg.mem_op;
  assign MEM_STROBE = s_reg.mem_strobe;
  assign MEM_ADDR = s_reg.mem_addr;
  assign MEM_WDATA = s_reg.mem_wdata;
  assign SPM_GRANT = s_reg.spm_grant;
  assign LPM_GRANT = s_reg.lpm_grant;
  assign IRQ_BLOCK = s_reg.irq_block;
  assign LOCK_BITS = s_reg.locks;
  assign BOOT_SIZE_SEL = s_reg.fuse_hi[`MLF_FH_SIZE_MSB:`MLF_FH_SIZE_LSB]; // R9
  assign RESET_VECTOR_TO_BOOT = s_reg.fuse_hi[`MLF_FH_RST_BOOT];
  assign RESET_VECTOR = s_reg.reset_vec;
  assign BROWNOUT_ENABLE = s_reg.bod_on; // R11
  assign BROWNOUT_LEVEL_FUSE = s_reg.fuse_lo[`MLF_FL_BOD_LEVEL];
  assign SERIAL_DOWNLOAD_ENABLE = s_reg.ser_on; // R12
  assign CLOCK_SOURCE_SEL = s_reg.fuse_lo[`MLF_FL_CLK_MSB:0]; // R13

endmodule

//--- mlf_defs.svh
`ifndef MLF_DEFS_SVH
`define MLF_DEFS_SVH

// Bit positions in the synchronised pin vector.
`define MLF_PIN_XA0      0
`define MLF_PIN_XA1      1
`define MLF_PIN_BS1      2
`define MLF_PIN_BS2      3
`define MLF_PIN_OE_N     4
`define MLF_PIN_WR_N     5
`define MLF_PIN_PAGE_LATCH_STROBE    6
`define MLF_PIN_XTAL     7
`define MLF_PIN_DATA_LSB 8
// Idle pin levels: selects idle, strobes low, active-low pins high, data bus zero.
`define MLF_PIN_IDLE     16'h0033

// Protection bit positions; a bit reads 1 unprogrammed, 0 programmed.
`define MLF_LK_MEM_A     0
`define MLF_LK_MEM_B     1
`define MLF_LK_APP_WR    2
`define MLF_LK_APP_RD    3
`define MLF_LK_BOOT_WR   4
`define MLF_LK_BOOT_RD   5
`define MLF_LOCK_RESET   6'h3f

// Low fuse byte layout and default.
`define MLF_FL_BOD_LEVEL 7
`define MLF_FL_BOD_EN    6
`define MLF_FL_SER_EN    5
`define MLF_FL_RSVD      4
`define MLF_FL_CLK_MSB   3
`define MLF_FUSE_LO_RESET 8'hd2

// High fuse layout and default.
`define MLF_FH_SIZE_MSB  2
`define MLF_FH_SIZE_LSB  1
`define MLF_FH_RST_BOOT  0
`define MLF_FUSE_HI_RESET 3'h7

// Boot section start word addresses, indexed by the boot size field.
`define MLF_BOOT_START_0 16'h1c00
`define MLF_BOOT_START_1 16'h1e00
`define MLF_BOOT_START_2 16'h1f00
`define MLF_BOOT_START_3 16'h1f80
`define MLF_APP_RESET_VEC 16'h0000

// Identification bytes (values arbitrary) and factory oscillator trim.
`define MLF_SIG_BYTE_0   8'h5a
`define MLF_SIG_BYTE_1   8'h3c
`define MLF_SIG_BYTE_2   8'h01
`define MLF_CAL_BYTE     8'h80
`define MLF_BLOCKED_READ 8'hff

// Self-timed programming duration.
`define MLF_CLK_MHZ      40
`define MLF_PROG_TIME_NS 8000
`define MLF_PROG_CYCLES  (((`MLF_PROG_TIME_NS * `MLF_CLK_MHZ) + 999) / 1000)

`endif

//--- mlf_pkg.sv
package mlf_pkg;

  typedef enum logic [1:0] {
    MLF_ACT_ADDR = 2'b00,
    MLF_ACT_DATA = 2'b01,
    MLF_ACT_CMD  = 2'b10,
    MLF_ACT_IDLE = 2'b11
  } mlf_action_t;

  typedef enum logic [7:0] {
    MLF_CMD_NOP      = 8'h00,
    MLF_CMD_ERASE    = 8'h80,
    MLF_CMD_WR_FUSE  = 8'h40,
    MLF_CMD_WR_LOCK  = 8'h20,
    MLF_CMD_WR_FLASH = 8'h10,
    MLF_CMD_WR_EE    = 8'h11,
    MLF_CMD_RD_SIG   = 8'h08,
    MLF_CMD_RD_FUSE  = 8'h04,
    MLF_CMD_RD_FLASH = 8'h02,
    MLF_CMD_RD_EE    = 8'h03
  } mlf_cmd_t;

  typedef enum logic [2:0] {
    MLF_MOP_NONE     = 3'b000,
    MLF_MOP_LATCH_LO = 3'b001,
    MLF_MOP_LATCH_HI = 3'b010,
    MLF_MOP_PAGE_WR  = 3'b011,
    MLF_MOP_EE_WR    = 3'b100,
    MLF_MOP_ERASE    = 3'b101,
    MLF_MOP_RD_FLASH = 3'b110,
    MLF_MOP_RD_EE    = 3'b111
  } mlf_mem_op_t;

  typedef struct packed {
    logic [15:0] s1;
    logic [15:0] s2;
    logic [3:0]  prev;
    logic [7:0]  cmd;
    logic [7:0]  addr_lo;
    logic [7:0]  addr_hi;
    logic [7:0]  data_lo;
    logic [7:0]  data_hi;
    logic [5:0]  locks;
    logic [7:0]  fuse_lo;
    logic [2:0]  fuse_hi;
    logic [11:0] busy_cnt;
    logic        ready;
    logic [7:0]  data_out;
    logic        data_oe;
    mlf_mem_op_t mem_op;
    logic        mem_strobe;
    logic [15:0] mem_addr;
    logic [7:0]  mem_wdata;
    logic        spm_grant;
    logic        lpm_grant;
    logic        irq_block;
    logic [15:0] reset_vec;
    logic        bod_on;
    logic        ser_on;
  } mlf_state_t;

endpackage

//--- mlf_prog_port_checker.sv
`timescale 1ns/1ps

module mlf_prog_port_checker (
  input wire logic                 CLOCK,            // Clock
  input wire logic                 RST_N,            // Reset
  input wire logic                 READY_BUSY_OUT,   // Ready
  input wire logic                 MEM_STROBE,       // Strobe
  input wire mlf_pkg::mlf_mem_op_t MEM_OP,           // Op code
  input wire logic [5:0]           LOCK_BITS,        // Locks
  input wire logic [3:0]           CLOCK_SOURCE_SEL, // Fuses
  input wire logic                 SPM_REQ,          // Store
  input wire logic                 SPM_TO_BOOT,      // Store target
  input wire logic                 SPM_GRANT,        // Store grant
  input wire logic                 LPM_REQ,          // Load
  input wire logic                 LPM_TO_BOOT,      // Load target
  input wire logic                 RUN_IN_BOOT,      // Boot code
  input wire logic                 LPM_GRANT,        // Load grant
  input wire logic                 IRQ_BLOCK         // Irq off
);
  import mlf_pkg::*;
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  logic [9:0] low_cnt;
  // A delay range cannot span the busy time cheaply, so the low cycles are counted.
  always_ff @(posedge CLOCK) begin
    if (!RST_N || READY_BUSY_OUT)
      low_cnt <= 10'h000;
    else
      low_cnt <= low_cnt + 10'h001;
  end
  a_busy_length: assert property ($rose(READY_BUSY_OUT) |-> low_cnt inside {[316:322]})
    else $error("busy time wrong");
  a_strobe_single: assert property (MEM_STROBE |=> !MEM_STROBE)
    else $error("strobe too long");
  a_write_locked: assert property (MEM_STROBE && MEM_OP inside {MLF_MOP_PAGE_WR, MLF_MOP_EE_WR}
    |-> LOCK_BITS[0]) else $error("write while locked");
  a_fuse_frozen: assert property (!LOCK_BITS[0] |=> $stable(CLOCK_SOURCE_SEL))
    else $error("fuse moved while locked");
  a_spm_app: assert property (SPM_REQ && !SPM_TO_BOOT && !LOCK_BITS[2] |=> !SPM_GRANT)
    else $error("app store granted");
  a_spm_boot: assert property (SPM_REQ && SPM_TO_BOOT && !LOCK_BITS[4] |=> !SPM_GRANT)
    else $error("boot store granted");
  a_lpm_app: assert property (LPM_REQ && RUN_IN_BOOT && !LPM_TO_BOOT && !LOCK_BITS[3]
    |=> !LPM_GRANT) else $error("app load granted");
  a_lpm_boot: assert property (LPM_REQ && !RUN_IN_BOOT && LPM_TO_BOOT && !LOCK_BITS[5]
    |=> !LPM_GRANT) else $error("boot load granted");
  a_irq_masked: assert property (RUN_IN_BOOT && !LOCK_BITS[5] |=> IRQ_BLOCK)
    else $error("irq not blocked");
endmodule

bind mlf_prog_port mlf_prog_port_checker u_chk (
  .CLOCK(CLOCK), .RST_N(RST_N), .READY_BUSY_OUT(READY_BUSY_OUT), .MEM_STROBE(MEM_STROBE),
  .MEM_OP(MEM_OP), .LOCK_BITS(LOCK_BITS), .CLOCK_SOURCE_SEL(CLOCK_SOURCE_SEL),
  .SPM_REQ(SPM_REQ), .SPM_TO_BOOT(SPM_TO_BOOT), .SPM_GRANT(SPM_GRANT), .LPM_REQ(LPM_REQ),
  .LPM_TO_BOOT(LPM_TO_BOOT), .RUN_IN_BOOT(RUN_IN_BOOT), .LPM_GRANT(LPM_GRANT),
  .IRQ_BLOCK(IRQ_BLOCK)
);

//--- mlf_prog_model.sv
`timescale 1ns/1ps

module mlf_prog_model (
  input  wire logic       clk,     // Clock
  output logic      [1:0] act_sel, // Action code
  output logic            bs_a,    // Byte select
  output logic            bs_b,    // Second byte select
  output logic            oe_n,    // Output enable
  output logic            wr_n,    // Write
  output logic            page_latch_strobe,   // Page latch
  output logic            xtal,    // Action strobe
  output logic      [7:0] pd       // Bus drive value
);
  localparam int PULSE = 20;
  initial begin
    act_sel = 2'b11;
    bs_a = 1'b0;
    bs_b = 1'b0;
    oe_n = 1'b1;
    wr_n = 1'b1;
    page_latch_strobe = 1'b0;
    xtal = 1'b0;
    pd = 8'h00;
  end
  task automatic hold(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Select lines settle several cycles before the strobe so the pin sync sees them first.
  task automatic act(input logic [1:0] a, input logic b, input logic [7:0] d);
    @(negedge clk);
    act_sel = a;
    bs_a = b;
    pd = d;
    hold(4);
    xtal = 1'b1;
    hold(PULSE);
    xtal = 1'b0;
    hold(PULSE);
  endtask
  task automatic strobe(input logic b, input logic pg);
    @(negedge clk);
    bs_a = b;
    hold(4);
    if (pg)
      page_latch_strobe = 1'b1;
    else
      wr_n = 1'b0;
    hold(PULSE);
    page_latch_strobe = 1'b0;
    wr_n = 1'b1;
    hold(8);
  endtask
  task automatic set_oe(input logic o, input logic b, input logic b2);
    @(negedge clk);
    bs_a = b;
    bs_b = b2;
    oe_n = o;
    hold(12);
  endtask
endmodule

//--- test_memory_lock_fuse_prog_port.sv
`timescale 1ns/1ps
`include "mlf_defs.svh"

module test_memory_lock_fuse_prog_port;
  import mlf_pkg::*;
  logic        CLOCK = 1'b0;
  logic        RST_N = 1'b0;
  logic [4:0]  cpu = 5'h00;
  logic [7:0]  rdata = 8'h00;
  logic [7:0]  pd, dout, bus, wd;
  logic [1:0]  sel, bsz;
  logic        bsa, bsb, oen, wrn, pgl, xt, doe, rdy, stb, rb, boe, bol, ser, sg, lg, irq;
  mlf_mem_op_t op;
  mlf_mem_op_t last_op = MLF_MOP_NONE;
  logic [15:0] madr, rvec;
  logic [5:0]  lk;
  logic [3:0]  cks;
  int          num_errors = 0;
  int          checked = 0;
  int          nstb = 0;
  always #12.5 CLOCK = ~CLOCK;
  // A released bus shows the inverse of its last value, so stale data cannot match.
  assign bus = doe ? dout : (oen ? pd : ~pd);
  always @(posedge CLOCK) begin
    if (stb) begin
      rdata <= madr[7:0] ^ 8'ha5;
      last_op <= op;
      nstb <= nstb + 1;
    end
  end
  mlf_prog_port DUT (
    .CLOCK(CLOCK), .RST_N(RST_N), .ACTION_SELECT_0(sel[0]), .ACTION_SELECT_1(sel[1]),
    .BYTE_SELECT_A(bsa), .BYTE_SELECT_B(bsb), .OUT_ENABLE_N(oen), .WRITE_N(wrn),
    .PAGE_LATCH_STROBE(pgl), .CRYSTAL_IN_STROBE(xt), .DATA_IN(bus), .DATA_OUT(dout),
    .DATA_OE(doe), .READY_BUSY_OUT(rdy), .MEM_OP(op), .MEM_STROBE(stb), .MEM_ADDR(madr),
    .MEM_WDATA(wd), .MEM_RDATA(rdata), .SPM_REQ(cpu[4]), .SPM_TO_BOOT(cpu[3]),
    .LPM_REQ(cpu[2]), .LPM_TO_BOOT(cpu[1]), .RUN_IN_BOOT(cpu[0]), .SPM_GRANT(sg),
    .LPM_GRANT(lg), .IRQ_BLOCK(irq), .LOCK_BITS(lk), .BOOT_SIZE_SEL(bsz),
    .RESET_VECTOR_TO_BOOT(rb), .RESET_VECTOR(rvec), .BROWNOUT_ENABLE(boe),
    .BROWNOUT_LEVEL_FUSE(bol), .SERIAL_DOWNLOAD_ENABLE(ser), .CLOCK_SOURCE_SEL(cks)
  );
  mlf_prog_model prg (
    .clk(CLOCK), .act_sel(sel), .bs_a(bsa), .bs_b(bsb), .oe_n(oen), .wr_n(wrn),
    .page_latch_strobe(pgl), .xtal(xt), .pd(pd)
  );
  task automatic give_verdict;
    $display("checked %0d, num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wait_ready;
    int n;
    n = 0;
    while (rdy !== 1'b1 && n < 1000) begin
      @(negedge CLOCK);
      n++;
    end
    if (n >= 1000) begin
      num_errors++;
      give_verdict();
    end
  endtask
  task automatic wr_cmd(input logic [7:0] c, input logic b, input logic [7:0] d);
    prg.act(MLF_ACT_CMD, 1'b0, c);
    prg.act(MLF_ACT_DATA, 1'b0, d);
    prg.strobe(b, 1'b0);
    wait_ready();
  endtask
  task automatic rd(input logic [7:0] c, hi, lo, input logic b, b2, input logic [7:0] e);
    prg.act(MLF_ACT_CMD, 1'b0, c);
    prg.act(MLF_ACT_ADDR, 1'b1, hi);
    prg.act(MLF_ACT_ADDR, 1'b0, lo);
    prg.set_oe(1'b0, b, b2);
    check(bus, e);
    prg.set_oe(1'b1, 1'b0, 1'b0);
  endtask
  task automatic cpu_set(input logic [4:0] v);
    @(negedge CLOCK);
    cpu = v;
    repeat (2) @(negedge CLOCK);
  endtask
  task automatic t_ids;
    check(lk, 6'h3f);
    check({bsz, rb, rvec}, 19'h70000);
    check({bol, boe, ser, cks, rdy}, 8'ha5);
    rd(MLF_CMD_RD_SIG, 8'h00, 8'h00, 1'b0, 1'b0, `MLF_SIG_BYTE_0);
    rd(MLF_CMD_RD_SIG, 8'h00, 8'h01, 1'b0, 1'b0, `MLF_SIG_BYTE_1);
    rd(MLF_CMD_RD_SIG, 8'h00, 8'h02, 1'b0, 1'b0, `MLF_SIG_BYTE_2);
    rd(MLF_CMD_RD_SIG, 8'h00, 8'h00, 1'b1, 1'b0, `MLF_CAL_BYTE);
    $display("ids done");
  endtask
  task automatic t_fuses;
    logic [15:0] st [4];
    st = '{`MLF_BOOT_START_0, `MLF_BOOT_START_1, `MLF_BOOT_START_2, `MLF_BOOT_START_3};
    wr_cmd(MLF_CMD_WR_FUSE, 1'b0, 8'h8f);
    check({boe, ser, cks}, 6'h3f);
    rd(MLF_CMD_RD_FUSE, 8'h00, 8'h00, 1'b0, 1'b0, 8'h9f);
    for (int i = 0; i < 4; i++) begin
      wr_cmd(MLF_CMD_WR_FUSE, 1'b1, {5'h00, i[1:0], 1'b0});
      check(rvec, st[i]);
    end
    rd(MLF_CMD_RD_FUSE, 8'h00, 8'h00, 1'b0, 1'b1, 8'hfe);
    wr_cmd(MLF_CMD_WR_FUSE, 1'b1, 8'h07);
    check(rvec, `MLF_APP_RESET_VEC);
    $display("fuses done");
  endtask
  task automatic t_mem;
    prg.act(MLF_ACT_CMD, 1'b0, MLF_CMD_WR_FLASH);
    prg.act(MLF_ACT_ADDR, 1'b0, 8'h12);
    prg.act(MLF_ACT_DATA, 1'b0, 8'h5c);
    prg.strobe(1'b0, 1'b1);
    check(last_op, MLF_MOP_LATCH_LO);
    check(wd, 8'h5c);
    prg.strobe(1'b0, 1'b0);
    wait_ready();
    check(last_op, MLF_MOP_PAGE_WR);
    wr_cmd(MLF_CMD_WR_EE, 1'b0, 8'h77);
    check(last_op, MLF_MOP_EE_WR);
    check(wd, 8'h77);
    rd(MLF_CMD_RD_FLASH, 8'h00, 8'h34, 1'b0, 1'b0, 8'h91);
    $display("mem done");
  endtask
  task automatic t_self;
    wr_cmd(MLF_CMD_WR_LOCK, 1'b0, 8'h03);
    check(lk, 6'h03);
    cpu_set(5'b10000);
    check(sg, 1'b0);
    cpu_set(5'b11000);
    check(sg, 1'b0);
    cpu_set(5'b00101);
    check({lg, irq}, 2'b01);
    cpu_set(5'b00110);
    check(lg, 1'b0);
    wr_cmd(MLF_CMD_ERASE, 1'b0, 8'h00);
    check({lk, cks}, 10'h3ff);
    check(last_op, MLF_MOP_ERASE);
    cpu_set(5'b11001);
    check({sg, irq}, 2'b10);
    cpu_set(5'b00110);
    check(lg, 1'b1);
    cpu_set(5'b00000);
    $display("self done");
  endtask
  task automatic t_modes;
    int n0;
    wr_cmd(MLF_CMD_WR_LOCK, 1'b0, 8'h3e);
    n0 = nstb;
    wr_cmd(MLF_CMD_WR_FUSE, 1'b0, 8'h80);
    wr_cmd(MLF_CMD_WR_EE, 1'b0, 8'h11);
    check(cks, 4'hf);
    check(nstb, n0);
    wr_cmd(MLF_CMD_WR_LOCK, 1'b0, 8'h3f);
    rd(MLF_CMD_RD_FUSE, 8'h00, 8'h00, 1'b1, 1'b0, 8'hfe);
    rd(MLF_CMD_RD_FLASH, 8'h00, 8'h21, 1'b0, 1'b0, 8'h84);
    wr_cmd(MLF_CMD_WR_LOCK, 1'b0, 8'h3c);
    rd(MLF_CMD_RD_FLASH, 8'h00, 8'h21, 1'b0, 1'b0, `MLF_BLOCKED_READ);
    rd(MLF_CMD_RD_EE, 8'h00, 8'h21, 1'b0, 1'b0, `MLF_BLOCKED_READ);
    prg.act(MLF_ACT_CMD, 1'b0, 8'h55);
    prg.strobe(1'b0, 1'b0);
    check(rdy, 1'b1);
    wr_cmd(MLF_CMD_ERASE, 1'b0, 8'h00);
    check(lk, 6'h3f);
    $display("modes done");
  endtask
  initial begin
    repeat (12) @(negedge CLOCK);
    RST_N = 1'b1;
    repeat (3) @(negedge CLOCK);
    t_ids();
    t_fuses();
    t_mem();
    t_self();
    t_modes();
    give_verdict();
  end
endmodule
